/* design/scs_consts.vh */
// Constants for the startup configuration and input select block
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SCS_CLK_MHZ 250
`define SCS_HOLDOFF_MS 10
`define SCS_LOAD_WINDOW_MS 1
`define SCS_SETTLE_CYCLES 4
`define SCS_GAP_CYCLES 4

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SCS_IDX_REG0 8'h00
`define SCS_IDX_INSEL 8'h13
`define SCS_IDX_STATUS 8'h20
`define SCS_IDX_CFGDATA 8'h21
`define SCS_IDX_W 8

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define SCS_REG0_LOADBIT 7
`define SCS_INSEL_PRIM 1
`define SCS_INSEL_SM_LO 2
`define SCS_INSEL_SM_HI 3
`define SCS_REG0_RST 8'h80
`define SCS_INSEL_RST 8'h00
`define SCS_ST_SWMODE 0
`define SCS_ST_IDX_LO 1
`define SCS_ST_IDX_HI 2
`define SCS_ST_SWDFLT 3
`define SCS_ST_REFSEL 4
`define SCS_ST_REFGATE 5
`define SCS_ST_RUNNING 6

`endif

/* design/scs_cfg_loader.v */
// Power-up mode capture and configuration selection
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.vh"

module scs_cfg_loader #(
  parameter CFG_W = 32,
  parameter HOLDOFF_CYCLES = `SCS_HOLDOFF_MS * 1000 * `SCS_CLK_MHZ,
  parameter SETTLE_CYCLES = `SCS_SETTLE_CYCLES,
  parameter [CFG_W-1:0] CFG0 = 32'h00000000,
  parameter [CFG_W-1:0] CFG1 = 32'h11111111,
  parameter [CFG_W-1:0] CFG2 = 32'h22222222,
  parameter [CFG_W-1:0] CFG3 = 32'h33333333,
  parameter [CFG_W-1:0] SW_DEFAULT = 32'h5a5a5a5a
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Board pins
  input wire mode_strap_pin,
  input wire config_select_low,
  input wire config_select_high,
  // Software side
  input wire load_at_powerup_bit,
  input wire sw_we,
  input wire [CFG_W-1:0] sw_data,
  // Results
  output reg hw_mode,
  output reg [1:0] cfg_index,
  output reg sw_dflt,
  output reg [CFG_W-1:0] active_cfg,
  output reg sync_reset,
  output reg running
);

  localparam [2:0] S_BOOT = 3'b001;
  localparam [2:0] S_HOLD = 3'b010;
  localparam [2:0] S_RUN = 3'b100;

  reg [2:0] state;
  reg [31:0] cnt;
  reg [1:0] pend_sel;
  wire [1:0] pin_sel;

  assign pin_sel = {config_select_high, config_select_low};

  function [CFG_W-1:0] bank;
    input [1:0] idx;
    begin
      case (idx)
        2'b00: bank = CFG0;
        2'b01: bank = CFG1;
        2'b10: bank = CFG2;
        default: bank = CFG3;
      endcase
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_BOOT;
      cnt <= 32'h0;
      pend_sel <= 2'b00;
      hw_mode <= 1'b0;
      cfg_index <= 2'b00;
      sw_dflt <= 1'b0;
      active_cfg <= {CFG_W{1'b0}};
      sync_reset <= 1'b0;
      running <= 1'b0;
    end else begin
      sync_reset <= 1'b0;
      case (state)
        // Strap and selects are caught once, on the first edge after release
        S_BOOT: begin
          hw_mode <= mode_strap_pin; // see R1, R14
          cnt <= 32'h0;
          state <= S_HOLD;
          if (mode_strap_pin) begin
            cfg_index <= pin_sel; // see R3, R5
            active_cfg <= bank(pin_sel); // see R3, R5
            pend_sel <= pin_sel;
            sync_reset <= 1'b1; // see R13
          end else if (load_at_powerup_bit) begin
            sw_dflt <= 1'b1; // see R4
            active_cfg <= SW_DEFAULT; // see R4
          end else begin
            active_cfg <= bank(2'b00); // see R4
          end
        end
        // Select pins are not watched until the hold-off has run out
        S_HOLD: begin
          if (cnt == HOLDOFF_CYCLES - 1) begin // see R6
            cnt <= 32'h0;
            running <= 1'b1;
            state <= S_RUN;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        S_RUN: begin
          if (hw_mode) begin
            // A new level must stand for a few cycles; a pin bouncing
            // through its edge would otherwise cause two reloads
            if (pin_sel != pend_sel) begin
              pend_sel <= pin_sel;
              cnt <= 32'h0;
            end else if (pend_sel != cfg_index) begin
              if (cnt == SETTLE_CYCLES - 1) begin
                cfg_index <= pend_sel; // see R8
                active_cfg <= bank(pend_sel); // see R8, R7
                sync_reset <= 1'b1; // see R13
                cnt <= 32'h0;
              end else begin
                cnt <= cnt + 32'h1;
              end
            end
          end
        end
        default: state <= S_BOOT;
      endcase
      // Software rewrite is allowed once boot has chosen the mode
      if (sw_we && !hw_mode && state != S_BOOT) begin
        active_cfg <= sw_data; // see R2
        sw_dflt <= 1'b0;
      end
    end
  end

endmodule // scs_cfg_loader

`default_nettype wire

/* design/scs_ref_switch.v */
// Reference source selection with break-before-make switchover
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.vh"

module scs_ref_switch #(
  parameter GAP_CYCLES = `SCS_GAP_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Selection inputs
  input wire input_select_pin,
  input wire primary_source_bit,
  input wire [1:0] switch_mode_field,
  // Results: 0 crystal/reference, 1 differential clock
  output reg ref_select,
  output reg ref_gate
);

  localparam [2:0] S_ON = 3'b001;
  localparam [2:0] S_OFF = 3'b010;
  localparam [2:0] S_BACK = 3'b100;

  reg [2:0] state;
  reg [7:0] gap;
  wire want;
  wire manual;

  assign want = input_select_pin ^ primary_source_bit; // see R9, R10
  assign manual = ~switch_mode_field[1]; // see R11

  // The reference is gated off before and after the source change so
  // that no runt period reaches the outputs; the cost is a short gap.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_ON;
      gap <= 8'h00;
      ref_select <= 1'b0;
      ref_gate <= 1'b1;
    end else begin
      case (state)
        S_ON: begin
          if (manual && want != ref_select) begin
            ref_gate <= 1'b0; // see R12
            gap <= 8'h00;
            state <= S_OFF;
          end
        end
        S_OFF: begin
          if (gap == GAP_CYCLES - 1) begin
            ref_select <= want; // see R9, R11
            gap <= 8'h00;
            state <= S_BACK;
          end else begin
            gap <= gap + 8'h01;
          end
        end
        S_BACK: begin
          if (gap == GAP_CYCLES - 1) begin
            ref_gate <= 1'b1; // see R12
            state <= S_ON;
          end else begin
            gap <= gap + 8'h01;
          end
        end
        default: state <= S_ON;
      endcase
    end
  end

endmodule // scs_ref_switch

`default_nettype wire

/* design/scs_top.v */
// Startup configuration and reference input select, APB top level
//
// Functional notes
// R1 - Strap low at power-up means software mode, high means hardware mode.
// R2 - Software mode lets the bus rewrite the configuration at any time.
// R3 - Hardware mode loads one of four configurations chosen by select pins.
// R4 - Software mode loads bus default if load bit set, else configuration 0.
// R5 - Select pins are stable through reset; their choice loads at power-up.
// R6 - Board must not change select pins for 10 ms after power-up.
// R7 - Board changes only one select pin at a time.
// R8 - After a pin change the new configuration loads within 1 ms.
// R9 - Crystal when input select equals primary bit, differential otherwise.
// R10 - Input select polarity sits in byte 0x13 bit 1, default 0.
// R11 - Switch mode field 0x means manual switchover by input select pin.
// R12 - Source switchover never glitches the outputs.
// R13 - Hardware mode issues divider sync reset at power-up and on reload.
// R14 - The sampled mode is held until the next power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "scs_consts.vh"

module scs_top #(
  parameter CFG_W = 32,
  parameter HOLDOFF_CYCLES = `SCS_HOLDOFF_MS * 1000 * `SCS_CLK_MHZ,
  parameter LOAD_WINDOW_CYCLES = `SCS_LOAD_WINDOW_MS * 1000 * `SCS_CLK_MHZ,
  parameter SETTLE_CYCLES = `SCS_SETTLE_CYCLES,
  parameter GAP_CYCLES = `SCS_GAP_CYCLES
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Board pins
  input wire mode_strap_pin,
  input wire config_select_low,
  input wire config_select_high,
  input wire input_select_pin,
  // Configuration and reference outputs
  output wire [CFG_W-1:0] active_config,
  output wire sync_reset,
  output wire sw_mode,
  output wire ref_select,
  output wire ref_gate
);

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  reg [7:0] reg0;
  reg [7:0] insel;
  wire hw_mode;
  wire [1:0] cfg_index;
  wire sw_dflt;
  wire running;
  wire [CFG_W-1:0] cfg_word;
  wire access;
  wire [`SCS_IDX_W-1:0] idx;
  wire aligned;
  wire hit;
  wire cfg_we;
  reg [31:0] next_rdata;
  reg mode_sw;
  reg mode_taken;

  assign access = psel & penable & pready;
  assign idx = paddr[`SCS_IDX_W+1:2];
  assign aligned = (paddr[1:0] == 2'b00) &&
                   (paddr[31:`SCS_IDX_W+2] == {(30-`SCS_IDX_W){1'b0}});

  function is_reg;
    input [`SCS_IDX_W-1:0] i;
    begin
      is_reg = (i == `SCS_IDX_REG0) || (i == `SCS_IDX_INSEL) ||
               (i == `SCS_IDX_STATUS) || (i == `SCS_IDX_CFGDATA);
    end
  endfunction

  assign hit = aligned && is_reg(idx);
  assign cfg_we = access && pwrite && hit && !hw_mode &&
                  (idx == `SCS_IDX_CFGDATA);

  assign active_config = cfg_word;
  assign sw_mode = mode_sw;

  // --------------------------------------------------------------------
  // Mode output
  // --------------------------------------------------------------------
  // Kept as its own flop so the pin is registered; it takes the strap on
  // the boot edge, the same edge on which the loader latches its mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sw <= 1'b1;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      mode_sw <= ~mode_strap_pin; // see R1, R14
      mode_taken <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    if (hit) begin
      case (idx)
        `SCS_IDX_REG0: next_rdata[7:0] = reg0;
        `SCS_IDX_INSEL: next_rdata[7:0] = insel;
        `SCS_IDX_STATUS: begin
          next_rdata[`SCS_ST_SWMODE] = ~hw_mode;
          next_rdata[`SCS_ST_IDX_HI:`SCS_ST_IDX_LO] = cfg_index;
          next_rdata[`SCS_ST_SWDFLT] = sw_dflt;
          next_rdata[`SCS_ST_REFSEL] = ref_select;
          next_rdata[`SCS_ST_REFGATE] = ref_gate;
          next_rdata[`SCS_ST_RUNNING] = running;
        end
        `SCS_IDX_CFGDATA: next_rdata[CFG_W-1:0] = cfg_word;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      reg0 <= `SCS_REG0_RST;
      insel <= `SCS_INSEL_RST;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        // Hardware mode has no bus write access; reads still show state
        pslverr <= ~hit | (pwrite & hw_mode); // see R1
        prdata <= pwrite ? 32'h00000000 : next_rdata;
      end else begin
        pslverr <= 1'b0;
      end
      if (access && pwrite && hit && !hw_mode) begin
        if (idx == `SCS_IDX_REG0) begin
          reg0 <= pwdata[7:0]; // see R2
        end
        if (idx == `SCS_IDX_INSEL) begin
          insel <= pwdata[7:0]; // see R10
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Submodules
  // --------------------------------------------------------------------
  scs_cfg_loader #(
    .CFG_W(CFG_W),
    .HOLDOFF_CYCLES(HOLDOFF_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_loader (
    .pclk(pclk),
    .presetn(presetn),
    .mode_strap_pin(mode_strap_pin),
    .config_select_low(config_select_low),
    .config_select_high(config_select_high),
    .load_at_powerup_bit(reg0[`SCS_REG0_LOADBIT]), // see R4
    .sw_we(cfg_we), // see R2
    .sw_data(pwdata[CFG_W-1:0]),
    .hw_mode(hw_mode),
    .cfg_index(cfg_index),
    .sw_dflt(sw_dflt),
    .active_cfg(cfg_word),
    .sync_reset(sync_reset),
    .running(running)
  );

  scs_ref_switch #(
    .GAP_CYCLES(GAP_CYCLES)
  ) u_switch (
    .pclk(pclk),
    .presetn(presetn),
    .input_select_pin(input_select_pin),
    .primary_source_bit(insel[`SCS_INSEL_PRIM]), // see R10
    .switch_mode_field(insel[`SCS_INSEL_SM_HI:`SCS_INSEL_SM_LO]), // see R11
    .ref_select(ref_select),
    .ref_gate(ref_gate)
  );

endmodule // scs_top

`default_nettype wire

/* verif/scs_board.sv */
// Board model driving the strap and configuration select pins
`timescale 1ns/1ps
`default_nettype none
module scs_board #(
  parameter int HOLD = 24,
  parameter int SPACE = 40
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Wanted levels from the bench
  input wire logic want_strap,
  input wire logic [1:0] want_sel,
  // Board pins
  output logic mode_strap_pin,
  output logic config_select_low,
  output logic config_select_high
);
  int wait_c;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Levels settle while reset is held
      mode_strap_pin <= want_strap;
      config_select_low <= want_sel[0];
      config_select_high <= want_sel[1];
      wait_c <= HOLD;
    end else if (wait_c != 0) begin
      wait_c <= wait_c - 1;
    end else if (want_sel[0] != config_select_low) begin
      // One pin per step, then the device is left alone for a while
      config_select_low <= want_sel[0];
      wait_c <= SPACE;
    end else if (want_sel[1] != config_select_high) begin
      config_select_high <= want_sel[1];
      wait_c <= SPACE;
    end
  end
endmodule // scs_board
`default_nettype wire

/* verif/scs_top_checker.sv */
// Assertion checker for the startup configuration top level
`timescale 1ns/1ps
`default_nettype none
module scs_top_checker #(
  parameter CFG_W = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and results
  input wire logic mode_strap_pin,
  input wire logic [CFG_W-1:0] active_config,
  input wire logic sync_reset,
  input wire logic sw_mode,
  input wire logic ref_select,
  input wire logic ref_gate
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Low up to the boot edge; first sampled high one edge after it
  logic booted;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      booted <= 1'b0;
    end else begin
      booted <= 1'b1;
    end
  end
  AST_PREADY_DUE: assert property (psel && !penable |-> ##[1:2] pready)
    else $error("access not answered in time");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_HW_NO_WRITE: assert property (pready && pwrite && !sw_mode |-> pslverr)
    else $error("write accepted in hardware mode");
  AST_STRAP_MODE: assert property (booted && !$past(booted) |-> sw_mode == !$past(mode_strap_pin))
    else $error("mode differs from strap");
  AST_MODE_HELD: assert property (booted && $past(booted) |-> $stable(sw_mode))
    else $error("mode changed after boot");
  AST_BOOT_SYNC: assert property (booted && !$past(booted) && $past(mode_strap_pin) |-> sync_reset)
    else $error("no sync reset at boot");
  AST_SYNC_HW: assert property (sync_reset |-> !sw_mode)
    else $error("sync reset in software mode");
  AST_SYNC_PULSE: assert property (sync_reset |=> !sync_reset)
    else $error("sync reset longer than one cycle");
  AST_HW_CFG_LOAD: assert property ($changed(active_config) && !sw_mode |-> sync_reset || $past(sync_reset))
    else $error("hardware config changed without sync");
  AST_BREAK_FIRST: assert property (!$stable(ref_select) |-> !ref_gate && !$past(ref_gate))
    else $error("source changed with gate open");
  AST_GATE_REOPEN: assert property ($fell(ref_gate) |-> ##[1:12] ref_gate)
    else $error("gate stayed closed");
  cover property (sync_reset);
  cover property ($fell(ref_gate));
  cover property (pready && pslverr);
endmodule // scs_top_checker
bind scs_top scs_top_checker #(.CFG_W(CFG_W)) u_scs_top_checker (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .pslverr, .mode_strap_pin, .active_config,
  .sync_reset, .sw_mode, .ref_select, .ref_gate);
`default_nettype wire

/* verif/startup_config_and_input_select_tb.sv */
// Self-checking bench for the startup configuration top level
`timescale 1ns/1ps
`default_nettype none
module startup_config_and_input_select_tb;
  localparam int HOLD = 20;
  logic pclk, presetn, psel, penable, pwrite, input_select_pin;
  logic [31:0] paddr, pwdata, prdata, active_config, seed, rd, wr;
  logic pready, pslverr, sync_reset, sw_mode, ref_select, ref_gate;
  logic mode_strap_pin, config_select_low, config_select_high, want_strap;
  logic [1:0] want_sel;
  logic err, prim, sm3, exp_ref;
  int n_fail, checked, cyc;
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  scs_top #(.HOLDOFF_CYCLES(HOLD)) u_scs_top (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_strap_pin,
    .config_select_low, .config_select_high, .input_select_pin, .active_config,
    .sync_reset, .sw_mode, .ref_select, .ref_gate);
  scs_board #(.HOLD(HOLD + 4)) u_scs_board (.pclk, .presetn, .want_strap,
    .want_sel, .mode_strap_pin, .config_select_low, .config_select_high);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] cfg_word(input logic [1:0] k);
    return 32'h11111111 * k;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic boot(input logic s, input logic [1:0] k);
    want_strap <= s;
    want_sel <= k;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, input_select_pin} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    want_strap = 1'b1;
    want_sel = 2'b00;
    seed = 32'd25;
    {n_fail, checked, cyc} = 0;
    for (int k = 0; k < 4; k++) begin
      boot(1'b1, k[1:0]);
      chk("hw config", active_config, cfg_word(k[1:0]));
      chk("hw mode", sw_mode, 1'b0);
      apb(1'b0, 8'h20, 32'h0);
      chk("hw status", rd[2:0], {k[1:0], 1'b0});
      apb(1'b1, 8'h21, xs());
      chk("hw write refused", err, 1'b1);
      chk("hw unchanged", active_config, cfg_word(k[1:0]));
    end
    $display("test hw_boot done");
    // From 3 to 0: the board moves the low pin first, giving 2 on the way
    want_sel <= 2'b00;
    repeat (45) @(posedge pclk);
    chk("hw step", active_config, cfg_word(2'b10));
    repeat (60) @(posedge pclk);
    chk("hw reselect", active_config, cfg_word(2'b00));
    $display("test hw_reselect done");
    boot(1'b0, 2'b11);
    chk("sw default", active_config, 32'h5a5a5a5a);
    chk("sw mode", sw_mode, 1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk("reg0 reset", rd, 32'h80);
    apb(1'b0, 8'h20, 32'h0);
    chk("sw status", {rd[3], rd[0]}, 2'b11);
    apb(1'b0, 8'h13, 32'h0);
    chk("insel reset", rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr = xs();
      apb(1'b1, 8'h21, wr);
      apb(1'b0, 8'h21, 32'h0);
      chk("sw readback", rd, wr);
      chk("sw config", active_config, wr);
    end
    apb(1'b0, 8'h05, 32'h0);
    chk("unmapped", err, 1'b1);
    $display("test sw_mode done");
    exp_ref = 1'b0;
    for (int i = 0; i < 12; i++) begin
      wr = xs();
      prim = wr[0];
      sm3 = (i > 8);
      apb(1'b1, 8'h13, {28'h0, sm3, 1'b0, prim, 1'b0});
      input_select_pin <= wr[5];
      repeat (24) @(posedge pclk);
      if (!sm3) exp_ref = wr[5] ^ prim;
      chk("ref select", ref_select, exp_ref);
      chk("ref gate", ref_gate, 1'b1);
    end
    $display("test ref_switch done");
    final_report();
  end
endmodule // startup_config_and_input_select_tb
`default_nettype wire
